/* include/bmc_pkg.sv */
// Shared constants and types for the biphase mark line codec
`default_nettype none
package bmc_pkg;
	// -----------------------------------------------------------
	// Timing
	// -----------------------------------------------------------
	localparam int CLK_FREQ_KHZ = 100000;
	localparam int BIT_RATE_KHZ = 300;
	// Half a bit period in clock cycles, rounded down
	localparam int HALF_BIT_CYC = CLK_FREQ_KHZ / (2 * BIT_RATE_KHZ);
	localparam int CNT_W = 12;
	// Receive interval thresholds: 3/4 and 3/2 of a bit period
	localparam int RX_HALF_MAX = (HALF_BIT_CYC * 3) / 2;
	localparam int RX_FULL_MAX = HALF_BIT_CYC * 3;
	localparam int TX_LEVEL_W = 4;
	localparam int FIFO_DEPTH = 16;

	// -----------------------------------------------------------
	// Carriers
	// -----------------------------------------------------------
	// One outbound bit; last marks the final bit of the message
	typedef struct packed {
		logic last;
		logic value;
	} tx_sym_t;

	// One decoded inbound bit
	typedef struct packed {
		logic valid;
		logic value;
	} rx_bit_t;

	// Transmit sequencer states, Gray along idle, run, close
	typedef enum logic [1:0] {
		TX_IDLE = 2'b00,
		TX_RUN = 2'b01,
		TX_CLOSE = 2'b11
	} tx_state_t;
endpackage : bmc_pkg
`default_nettype wire

/* logic/bmc_phy.sv */
// Biphase mark line codec with its outbound bit FIFO
`timescale 1ns/1ns
`default_nettype none

// -------------------------------------------------------------------
// Synchronous FIFO
// -------------------------------------------------------------------
module bit_fifo
#(
	parameter int WIDTH = 2,
	parameter int DEPTH = 16
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire logic [WIDTH-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [WIDTH-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] fill_r;
	logic push;
	logic pop;

	// Refuse sizes that the pointer wrap cannot serve
	if (WIDTH < 1 || DEPTH < 2 || (1 << AW) != DEPTH)
	begin : g_bad_size
		$error("bit_fifo: DEPTH must be a power of two");
	end

	// Handshake qualifiers
	assign in_ready = (fill_r != DEPTH[AW:0]);
	assign out_valid = (fill_r != '0);
	assign push = in_valid && in_ready;
	assign pop = out_ready && out_valid;
	assign out_data = mem[rd_r];

	// Storage write
	always_ff @(posedge clk)
	begin
		if (push)
			mem[wr_r] <= in_data;
	end

	// Pointers and fill level
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			wr_r <= '0;
			rd_r <= '0;
			fill_r <= '0;
		end
		else
		begin
			if (push)
				wr_r <= wr_r + 1'b1;
			if (pop)
				rd_r <= rd_r + 1'b1;
			if (push && !pop)
				fill_r <= fill_r + 1'b1;
			else if (pop && !push)
				fill_r <= fill_r - 1'b1;
		end
	end
endmodule : bit_fifo

// -------------------------------------------------------------------
// Codec top
// -------------------------------------------------------------------
module bmc_phy
	import bmc_pkg::*;
#(
	parameter int HALF_CYC = HALF_BIT_CYC,
	parameter int LEVEL_W = TX_LEVEL_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire tx_sym_t tx_sym,
	input wire logic tx_valid,
	output logic tx_ready,
	output rx_bit_t rx_bit,
	output logic rx_active,
	output logic tx_busy,
	input wire logic orient_b,
	input wire logic [LEVEL_W-1:0] tx_peak_level,
	output logic [LEVEL_W-1:0] tx_drive_level,
	input wire logic channel_pin_a_i,
	output logic channel_pin_a_o,
	output logic channel_pin_a_oe,
	input wire logic channel_pin_b_i,
	output logic channel_pin_b_o,
	output logic channel_pin_b_oe
);
	// Refuse timings that the interval counter cannot hold
	if (HALF_CYC < 2 || HALF_CYC * 3 >= (1 << CNT_W) || LEVEL_W < 1)
	begin : g_bad_param
		$error("bmc_phy: half bit count or level width out of range");
	end

	localparam logic [CNT_W-1:0] HALF_LAST = CNT_W'(HALF_CYC - 1);
	localparam logic [CNT_W-1:0] RX_HALF_LIM = CNT_W'((HALF_CYC * 3) / 2);
	localparam logic [CNT_W-1:0] RX_FULL_LIM = CNT_W'(HALF_CYC * 3);

	tx_state_t state_r;
	tx_sym_t cur_r;
	tx_sym_t fifo_sym;
	logic fifo_valid;
	logic pop;
	logic fifo_in_ready;
	logic tx_push;
	logic [CNT_W-1:0] cnt_r;
	logic phase_r;
	logic level_r;
	logic orient_r;
	logic [LEVEL_W-1:0] peak_r;
	logic [LEVEL_W-1:0] drive_lvl_r;
	logic pin_a_r;
	logic pin_a_oe_r;
	logic pin_b_r;
	logic pin_b_oe_r;
	logic tx_ready_r;
	logic busy_r;
	logic [1:0] sync_a_r;
	logic [1:0] sync_b_r;
	logic rx_prev_r;
	logic rx_line;
	logic rx_edge;
	logic [CNT_W-1:0] rx_cnt_r;
	logic rx_act_r;
	logic rx_half_r;
	rx_bit_t rx_bit_r;

	// Offered bits are taken only while ready is shown
	assign tx_push = tx_valid && tx_ready_r;

	// Outbound bit buffer
	bit_fifo #(
		.WIDTH($bits(tx_sym_t)),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.clk(clk),
		.nrst(nrst),
		.in_data(tx_sym),
		.in_valid(tx_push),
		.in_ready(fifo_in_ready),
		.out_data(fifo_sym),
		.out_valid(fifo_valid),
		.out_ready(pop)
	);

	// -----------------------------------------------------------
	// Transmit sequencer
	// -----------------------------------------------------------
	// Fetch a bit at message start or at each bit boundary, except after a bit marked last
	assign pop = fifo_valid && ((state_r == TX_IDLE && !rx_act_r)
		|| (state_r == TX_RUN && cnt_r == '0 && phase_r && !cur_r.last));

	// Bit timing, level toggling and line state
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			state_r <= TX_IDLE;
			cur_r <= '0;
			cnt_r <= '0;
			phase_r <= 1'b0;
			level_r <= 1'b0;
		end
		else
		begin
			case (state_r)
				TX_IDLE:
				begin
					if (pop)
					begin
						level_r <= 1'b0;
						cur_r <= fifo_sym;
						cnt_r <= HALF_LAST;
						phase_r <= 1'b0;
						state_r <= TX_RUN;
					end
				end
				TX_RUN:
				begin
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else if (!phase_r)
					begin
						level_r <= level_r ^ cur_r.value;
						phase_r <= 1'b1;
						cnt_r <= HALF_LAST;
					end
					else
					begin
						level_r <= ~level_r;
						phase_r <= 1'b0;
						cnt_r <= HALF_LAST;
						if (pop)
							cur_r <= fifo_sym;
						else
							state_r <= TX_CLOSE;
					end
				end
				TX_CLOSE:
				begin
					// closing level held only half a bit
					if (cnt_r != '0)
						cnt_r <= cnt_r - 1'b1;
					else
						state_r <= TX_IDLE;
				end
				default:
					state_r <= TX_IDLE;
			endcase
		end
	end

	// Orientation and peak level captured per message
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			orient_r <= 1'b0;
			peak_r <= '0;
		end
		else if (state_r == TX_IDLE && !rx_act_r)
		begin
			orient_r <= orient_b;
			peak_r <= tx_peak_level;
		end
	end

	// Pin drivers
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			pin_a_r <= 1'b0;
			pin_a_oe_r <= 1'b0;
			pin_b_r <= 1'b0;
			pin_b_oe_r <= 1'b0;
			drive_lvl_r <= '0;
			busy_r <= 1'b0;
			tx_ready_r <= 1'b0;
		end
		else
		begin
			// enable only while a message is on the line
			// only the selected pin is driven
			pin_a_oe_r <= (state_r != TX_IDLE) && !orient_r;
			pin_b_oe_r <= (state_r != TX_IDLE) && orient_r;
			pin_a_r <= level_r && (state_r != TX_IDLE) && !orient_r;
			pin_b_r <= level_r && (state_r != TX_IDLE) && orient_r;
			// peak setting sets the driven high level
			drive_lvl_r <= (level_r && state_r != TX_IDLE) ? peak_r : '0;
			busy_r <= (state_r != TX_IDLE);
			// Ready rests a cycle after each push, so the registered
			// flag never offers room that the FIFO no longer has
			tx_ready_r <= fifo_in_ready && !tx_push;
		end
	end

	// -----------------------------------------------------------
	// Receive decoder
	// -----------------------------------------------------------
	// Two-stage synchronisers on both channel pins
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			// Biased idle level, so no false edge follows reset
			sync_a_r <= '1;
			sync_b_r <= '1;
		end
		else
		begin
			sync_a_r <= {sync_a_r[0], channel_pin_a_i};
			sync_b_r <= {sync_b_r[0], channel_pin_b_i};
		end
	end

	// listen on the selected pin only
	assign rx_line = orient_r ? sync_b_r[1] : sync_a_r[1];
	assign rx_edge = (rx_line != rx_prev_r);

	// Interval measurement and bit classification
	always_ff @(posedge clk)
	begin
		if (!nrst)
		begin
			rx_prev_r <= 1'b1;
			rx_cnt_r <= '0;
			rx_act_r <= 1'b0;
			rx_half_r <= 1'b0;
			rx_bit_r <= '0;
		end
		else
		begin
			rx_prev_r <= rx_line;
			rx_bit_r <= '0;
			if (state_r != TX_IDLE)
			begin
				rx_act_r <= 1'b0;
				rx_half_r <= 1'b0;
				rx_cnt_r <= '0;
			end
			else if (rx_edge)
			begin
				rx_cnt_r <= '0;
				// any first edge seen just starts timing
				rx_act_r <= 1'b1;
				if (rx_act_r)
				begin
					// half pairs give one, full gives zero
					if (rx_cnt_r < RX_HALF_LIM)
					begin
						rx_half_r <= ~rx_half_r;
						rx_bit_r <= '{valid: rx_half_r, value: 1'b1};
					end
					else
					begin
						rx_half_r <= 1'b0;
						rx_bit_r <= '{valid: 1'b1, value: 1'b0};
					end
				end
			end
			else if (rx_cnt_r >= RX_FULL_LIM)
			begin
				// Line quiet too long: message over
				rx_act_r <= 1'b0;
				rx_half_r <= 1'b0;
			end
			else
				rx_cnt_r <= rx_cnt_r + 1'b1;
		end
	end

	// Registered outputs
	assign channel_pin_a_o = pin_a_r;
	assign channel_pin_a_oe = pin_a_oe_r;
	assign channel_pin_b_o = pin_b_r;
	assign channel_pin_b_oe = pin_b_oe_r;
	assign tx_drive_level = drive_lvl_r;
	assign tx_busy = busy_r;
	assign tx_ready = tx_ready_r;
	assign rx_bit = rx_bit_r;
	assign rx_active = rx_act_r;
endmodule : bmc_phy
`default_nettype wire

/* tb/bmc_checker.sv */
// Port checker for the biphase mark codec
`timescale 1ns/1ns
`default_nettype none
module bmc_checker
	import bmc_pkg::*;
#(
	parameter int HALF_CYC = HALF_BIT_CYC,
	parameter int LEVEL_W = TX_LEVEL_W
)
(
	input wire logic clk,
	input wire logic nrst,
	input wire tx_sym_t tx_sym,
	input wire logic tx_valid,
	input wire logic tx_ready,
	input wire rx_bit_t rx_bit,
	input wire logic rx_active,
	input wire logic tx_busy,
	input wire logic orient_b,
	input wire logic [LEVEL_W-1:0] tx_peak_level,
	input wire logic [LEVEL_W-1:0] tx_drive_level,
	input wire logic channel_pin_a_i,
	input wire logic channel_pin_a_o,
	input wire logic channel_pin_a_oe,
	input wire logic channel_pin_b_i,
	input wire logic channel_pin_b_o,
	input wire logic channel_pin_b_oe
);
	logic [CNT_W-1:0] cnt_r;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Cycles since the last edge on pin a
	always_ff @(posedge clk)
	begin
		if (!nrst || !channel_pin_a_oe)
			cnt_r <= 12'h000;
		else if ($changed(channel_pin_a_o))
			cnt_r <= 12'h001;
		else
			cnt_r <= cnt_r + 12'h001;
	end
	sequence s_release;
		$fell(channel_pin_a_oe);
	endsequence
	a_one_driver:
		assert property (!(channel_pin_a_oe && channel_pin_b_oe))
		else $error("Both channel pins driven");
	a_low_start:
		assert property ($rose(channel_pin_a_oe) |-> !channel_pin_a_o)
		else $error("Frame did not start low");
	a_level_zero:
		assert property (!(channel_pin_a_oe && channel_pin_a_o) &&
			!(channel_pin_b_oe && channel_pin_b_o) |-> tx_drive_level == '0)
		else $error("Drive level not zero while low");
	a_edge_space:
		assert property (channel_pin_a_oe && $past(channel_pin_a_oe) &&
			$changed(channel_pin_a_o) |-> cnt_r == CNT_W'(HALF_CYC) ||
			cnt_r == CNT_W'(2 * HALF_CYC))
		else $error("Edge spacing wrong");
	a_max_gap:
		assert property (channel_pin_a_oe |-> cnt_r <= CNT_W'(2 * HALF_CYC))
		else $error("Edge missing");
	a_close_hold:
		assert property (s_release |-> cnt_r == CNT_W'(HALF_CYC))
		else $error("Closing level hold wrong");
	a_rx_pulse:
		assert property (rx_bit.valid |=> !rx_bit.valid)
		else $error("Decoded bit pulse too long");
	a_rx_active:
		assert property (rx_bit.valid |-> rx_active)
		else $error("Bit decoded outside reception");
	a_busy_drive:
		assert property ((channel_pin_a_oe || channel_pin_b_oe) == tx_busy)
		else $error("Pin enable and busy disagree");
	a_rx_mute:
		assert property (tx_busy |-> !rx_bit.valid)
		else $error("Bit decoded while transmitting");
endmodule : bmc_checker
bind bmc_phy bmc_checker #(.HALF_CYC(HALF_CYC), .LEVEL_W(LEVEL_W)) chk (
	.clk(clk), .nrst(nrst), .tx_sym(tx_sym), .tx_valid(tx_valid),
	.tx_ready(tx_ready), .rx_bit(rx_bit), .rx_active(rx_active),
	.tx_busy(tx_busy), .orient_b(orient_b), .tx_peak_level(tx_peak_level),
	.tx_drive_level(tx_drive_level), .channel_pin_a_i(channel_pin_a_i),
	.channel_pin_a_o(channel_pin_a_o), .channel_pin_a_oe(channel_pin_a_oe),
	.channel_pin_b_i(channel_pin_b_i), .channel_pin_b_o(channel_pin_b_o),
	.channel_pin_b_oe(channel_pin_b_oe));
`default_nettype wire

/* tb/pd_partner.sv */
// Remote port model sending biphase mark frames
`timescale 1ns/1ns
`default_nettype none
module pd_partner
#(
	parameter int HALF_CYC = 8
)
(
	input wire logic clk,
	output logic line_o,
	output logic line_oe
);
	initial
	begin
		line_o = 1'b0;
		line_oe = 1'b0;
	end
	task automatic send(input logic [15:0] bits, input int n, input logic skip);
		logic lvl;
		lvl = skip;
		@(posedge clk) #1;
		line_oe = 1'b1;
		for (int i = 0; i < n; i++)
		begin
			line_o = lvl;
			repeat (HALF_CYC) @(posedge clk);
			#1 line_o = lvl ^ bits[i];
			repeat (HALF_CYC) @(posedge clk);
			#1 lvl = !(lvl ^ bits[i]);
		end
		line_o = lvl;
		repeat (HALF_CYC) @(posedge clk);
		#1 line_oe = 1'b0;
		line_o = !lvl; // Stale level never shows
	endtask : send
endmodule : pd_partner
`default_nettype wire

/* tb/tb_top.sv */
// Self-checking bench for the biphase mark codec
`timescale 1ns/1ns
`default_nettype none
module tb_top;
	import bmc_pkg::*;
	localparam int HC = 8;
	logic clk = 1'b0;
	logic nrst = 1'b0;
	tx_sym_t tx_sym = 2'h0;
	logic tx_valid = 1'b0;
	logic orient_b = 1'b0;
	logic p_b = 1'b0;
	logic [3:0] peak = 4'ha;
	logic tx_ready, rx_active, tx_busy, a_o, a_oe, b_o, b_oe, p_o, p_oe;
	logic a_w, b_w;
	logic [3:0] lvl_out;
	rx_bit_t rx_bit;
	int err_count = 0;
	int n_compared = 0;
	logic q[$];
	always #5 clk = !clk;
	// Bias pulls an undriven wire high
	assign a_w = a_oe ? a_o : (p_oe && !p_b) ? p_o : 1'b1;
	assign b_w = b_oe ? b_o : (p_oe && p_b) ? p_o : 1'b1;
	bmc_phy #(.HALF_CYC(HC), .LEVEL_W(4)) dut (.clk(clk), .nrst(nrst),
		.tx_sym(tx_sym), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.rx_bit(rx_bit), .rx_active(rx_active), .tx_busy(tx_busy),
		.orient_b(orient_b), .tx_peak_level(peak), .tx_drive_level(lvl_out),
		.channel_pin_a_i(a_w), .channel_pin_a_o(a_o), .channel_pin_a_oe(a_oe),
		.channel_pin_b_i(b_w), .channel_pin_b_o(b_o), .channel_pin_b_oe(b_oe));
	pd_partner #(.HALF_CYC(HC)) partner (.clk(clk), .line_o(p_o),
		.line_oe(p_oe));
	// Collect decoded bits
	always @(posedge clk)
		if (rx_bit.valid === 1'b1)
			q.push_back(rx_bit.value);
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			err_count++;
			$display("ERROR t=%0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	// Count in high byte, bits in low byte
	function automatic logic [15:0] qword();
		logic [15:0] w;
		w = 16'(q.size()) << 8;
		for (int i = 0; i < q.size() && i < 8; i++)
			w[i] = q[i];
		return w;
	endfunction : qword
	// Fill FIFO during reception, then check the frame sent
	task automatic tx_fill_send;
		logic [15:0] pat;
		logic [7:0] ex;
		logic lv;
		int t;
		pat = 16'hb1e5;
		lv = 1'b0;
		t = 0;
		fork
			partner.send(16'h002a, 6, 1'b0);
		join_none
		while (rx_active !== 1'b1 && t < 50)
		begin
			@(posedge clk) #1;
			t++;
		end
		chk(16'(rx_active), 16'h0001);
		// Each bit stands until ready is seen before the taking edge
		tx_valid = 1'b1;
		for (int i = 0; i < 16; i++)
		begin
			tx_sym = {i == 15, pat[i]};
			t = 0;
			while (tx_ready !== 1'b1 && t < 8)
			begin
				@(posedge clk) #1;
				t++;
			end
			chk(16'(tx_ready), 16'h0001);
			@(posedge clk) #1;
		end
		tx_valid = 1'b0;
		repeat (2) @(posedge clk);
		#1 chk(16'({tx_ready, tx_busy, a_oe}), 16'h0000);
		wait fork;
		chk(qword(), 16'h062a);
		t = 0;
		while (a_oe !== 1'b1 && t < 400)
		begin
			@(posedge clk) #1;
			t++;
		end
		// Orientation and peak change mid-message must not take effect
		orient_b = 1'b1;
		peak = 4'h5;
		repeat (HC / 2) @(posedge clk);
		for (int h = 0; h < 33; h++)
		begin
			ex = {2'h3, lv, 1'b0, lv ? 4'ha : 4'h0};
			#1 chk({tx_busy, a_oe, a_o, b_oe, lvl_out}, ex);
			lv = h[0] ? !lv : lv ^ pat[h / 2];
			repeat (HC) @(posedge clk);
		end
		#1 chk(16'({tx_busy, a_oe}), 16'h0000);
		orient_b = 1'b0;
	endtask : tx_fill_send
	// Wrong pin ignored, then a frame whose first edge is lost
	task automatic rx_orient_skip;
		p_b = 1'b1;
		q.delete();
		partner.send(16'h0016, 6, 1'b0);
		repeat (4 * HC) @(posedge clk);
		#1 chk(qword(), 16'h0000);
		orient_b = 1'b1;
		partner.send(16'h0036, 6, 1'b1);
		repeat (4 * HC) @(posedge clk);
		#1 chk(qword(), 16'h051b);
	endtask : rx_orient_skip
	task automatic print_verdict;
		if (err_count == 0 && n_compared > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict
	initial
	begin
		repeat (20) @(posedge clk);
		#1 nrst = 1'b1;
		tx_fill_send();
		rx_orient_skip();
		print_verdict();
	end
	initial
	begin
		#100000;
		err_count++;
		print_verdict();
	end
endmodule : tb_top
`default_nettype wire
